// file: include/rfs_pkg.sv
/*
 * Constants and types for the receive frame store and error counters.
 * Assumes a single 50 MHz core clock and bytes already deserialised and
 * SFD-aligned by the receive front end; address filter result supplied.
 */
package rfs_pkg;

	localparam int          FIFO_DEPTH      = 8;
	localparam int          FIFO_WIDTH      = 32;
	localparam logic [3:0]  BURST_LEVEL     = 4'h6;
	localparam logic [10:0] LONG_FRAME_MAX  = 11'h5EE;
	localparam logic [2:0]  ADDR_BYTES      = 3'h6;
	localparam logic [7:0]  CNT_MAX         = 8'hFF;
	localparam logic [7:0]  CNT_IRQ_LEVEL   = 8'hC0;
	localparam logic [7:0]  CNT_RESET       = 8'h00;

	// Status word field positions
	localparam int ST_OK      = 0;
	localparam int ST_CRC     = 1;
	localparam int ST_ALIGN   = 2;
	localparam int ST_LONG    = 3;
	localparam int ST_MISSED  = 4;
	localparam int ST_ABORT   = 5;
	localparam int ST_LEN_LSB = 16;

	typedef enum logic [1:0] {
		RFS_IDLE,
		RFS_ADDR,
		RFS_DATA,
		RFS_DROP
	} rfs_phase_t;

endpackage

// file: include/rfs_stream_if.sv
/*
 * Word stream carrier between frame logic and its FIFO.
 * Assumes both ends share core_clk_i.
 */
`timescale 1ns/100ps
interface rfs_stream_if;
	logic [31:0] data;
	logic        valid;
	logic        ready;
	logic        flush;
	logic [3:0]  level;
	modport src (output data, output valid, output flush, input ready, input level);
	modport snk (input data, input valid, input flush, output ready, output level);
endinterface

// file: hdl/rfs_fifo.sv
/*
 * Parameterised word FIFO with valid/ready on both sides and flush.
 * Assumes the drain side honours out_ready back-pressure.
 */
`timescale 1ns/100ps
module rfs_fifo
	import rfs_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             core_clk_i,
	input  wire logic             reset_n_i,
	// Fill side
	rfs_stream_if.snk             in_s,
	// Drain side
	output logic [WIDTH-1:0]      out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} rfs_fifo_st_t;

	rfs_fifo_st_t         st;
	rfs_fifo_st_t         next_st;
	logic [WIDTH-1:0]     mem [DEPTH];
	logic                 push;
	logic                 pop;

	assign out_valid_o = (st.cnt != '0);
	assign out_data_o  = mem[st.rp];
	assign in_s.ready  = (st.cnt != (AW+1)'(DEPTH));
	assign in_s.level  = 4'(st.cnt);
	assign push        = in_s.valid & in_s.ready & ~in_s.flush;
	assign pop         = out_valid_o & out_ready_i & ~in_s.flush;

	always_comb begin
		next_st = st;
		if (in_s.flush) begin
			next_st = '0;
		end else begin
			if (push) begin
				next_st.wp = st.wp + 1'b1;
			end
			if (pop) begin
				next_st.rp = st.rp + 1'b1;
			end
			next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Storage has no reset; occupancy guards every read
	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem[st.wp] <= in_s.data;
		end
	end
endmodule

// file: hdl/rfs_top.sv
/*
 * Receive frame store: packs post-SFD bytes into an eight-dword FIFO,
 * bursts to local memory, checks errors, posts status, counts events.
 * Assumes the front end gives SFD-aligned bytes, an address verdict after
 * the sixth byte, a CRC-good verdict at frame end, and read strobes.
 */
`timescale 1ns/100ps
module rfs_top
	import rfs_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        reset_n_i,
	// Configuration
	input  wire logic        monitor_mode_i,
	input  wire logic        accept_errored_i,
	input  wire logic        long_check_en_i,
	// Receive byte stream
	input  wire logic        sfd_i,
	input  wire logic [7:0]  byte_i,
	input  wire logic        byte_valid_i,
	input  wire logic        frame_end_i,
	input  wire logic        crc_good_i,
	input  wire logic        odd_bits_i,
	input  wire logic        rx_er_i,
	input  wire logic        rx_dv_i,
	input  wire logic        addr_match_valid_i,
	input  wire logic        addr_match_i,
	// Local memory
	output logic             burst_req_o,
	input  wire logic        burst_ack_i,
	output logic [31:0]      mem_data_o,
	output logic             mem_valid_o,
	input  wire logic        mem_ready_i,
	input  wire logic        mem_full_i,
	output logic [31:0]      mem_status_o,
	output logic             mem_status_valid_o,
	// Status and counters
	output logic [31:0]      rx_status_o,
	output logic             overflow_irq_o,
	output logic             rx_error_irq_o,
	output logic             counter_irq_o,
	input  wire logic        crc_cnt_rd_i,
	input  wire logic        align_cnt_rd_i,
	input  wire logic        missed_cnt_rd_i,
	output logic [7:0]       crc_error_counter_o,
	output logic [7:0]       align_error_counter_o,
	output logic [7:0]       missed_frame_counter_o
);

	// ****************************************
	// Counter update helper
	// ****************************************
	function automatic logic [7:0] cnt_next(input logic [7:0] c, input logic inc,
						input logic rd);
		logic [7:0] base;
		base = rd ? CNT_RESET : c;
		if (inc && base != CNT_MAX) begin
			cnt_next = base + 8'h01;
		end else begin
			cnt_next = base;
		end
	endfunction

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		rfs_phase_t  phase;
		logic [2:0]  addr_cnt;
		logic [1:0]  lane;
		logic [31:0] word;
		logic        word_valid;
		logic [10:0] len;
		logic        rx_err;
		logic        aborted;
		logic        missed_mem;
		logic [31:0] status;
		logic [31:0] mstatus;
		logic        mstatus_valid;
		logic        ovf_irq;
		logic        err_irq;
		logic        cnt_irq;
		logic        req;
		logic [7:0]  crc_cnt;
		logic [7:0]  aln_cnt;
		logic [7:0]  mis_cnt;
	} rfs_state_t;

	rfs_state_t  st;
	rfs_state_t  next_st;
	rfs_stream_if fifo_s ();

	rfs_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk_i  (core_clk_i),
		.reset_n_i   (reset_n_i),
		.in_s        (fifo_s),
		.out_data_o  (mem_data_o),
		.out_valid_o (mem_valid_o),
		.out_ready_i (mem_ready_i)
	);

	// Memory drains whenever mem_ready_i is high, burst granted or not; that is the back-pressure
	logic storing;
	logic crc_bad;
	logic is_long;
	logic inc_crc;
	logic inc_aln;
	logic inc_mis;
	logic frame_ok;
	logic [7:0] nc;
	logic [7:0] na;
	logic [7:0] nm;

	assign fifo_s.data  = st.word;
	assign fifo_s.valid = st.word_valid;
	assign storing      = (st.phase == RFS_ADDR || st.phase == RFS_DATA) && !monitor_mode_i;

	always_comb begin
		next_st            = st;
		next_st.ovf_irq    = 1'b0;
		next_st.err_irq    = 1'b0;
		next_st.cnt_irq    = 1'b0;
		next_st.mstatus_valid = 1'b0;
		fifo_s.flush       = 1'b0;
		crc_bad            = 1'b0;
		is_long            = 1'b0;
		inc_crc            = 1'b0;
		inc_aln            = 1'b0;
		inc_mis            = 1'b0;
		frame_ok           = 1'b0;
		if (fifo_s.ready) begin
			next_st.word_valid = 1'b0;
		end
		// Burst request held until acknowledged with the level below BURST_LEVEL
		if (fifo_s.level >= BURST_LEVEL) begin
			next_st.req = 1'b1;
		end else if (burst_ack_i) begin
			next_st.req = 1'b0;
		end
		if (rx_er_i && rx_dv_i && st.phase != RFS_IDLE) begin
			next_st.rx_err = 1'b1;
		end
		unique case (st.phase)
			RFS_IDLE: begin
				if (sfd_i) begin
					next_st.phase      = RFS_ADDR;
					next_st.addr_cnt   = '0;
					next_st.lane       = '0;
					next_st.len        = '0;
					next_st.rx_err     = 1'b0;
					next_st.aborted    = 1'b0;
					next_st.missed_mem = 1'b0;
				end
			end
			RFS_ADDR, RFS_DATA: begin
				if (byte_valid_i) begin
					next_st.len = (st.len == '1) ? st.len : st.len + 11'h001;
					next_st.word[8*st.lane +: 8] = byte_i;
					next_st.lane = st.lane + 2'h1;
					// Dword packs little-endian, one path word per four bytes
					if (st.lane == 2'h3 && storing) begin
						next_st.word_valid = 1'b1;
					end
					if (st.phase == RFS_ADDR && st.addr_cnt != ADDR_BYTES) begin
						next_st.addr_cnt = st.addr_cnt + 3'h1;
					end
				end
				if (st.phase == RFS_ADDR && addr_match_valid_i) begin
					if (addr_match_i) begin
						next_st.phase = RFS_DATA;
					end else begin
						next_st.phase = RFS_DROP;
						fifo_s.flush  = 1'b1;
						next_st.word_valid = 1'b0;
					end
				end
				if (mem_full_i && storing && !frame_end_i) begin
					next_st.phase      = RFS_DROP;
					next_st.aborted    = 1'b1;
					next_st.missed_mem = 1'b1;
					next_st.ovf_irq    = 1'b1;
					fifo_s.flush       = 1'b1;
					next_st.word_valid = 1'b0;
				end
			end
			RFS_DROP: begin
				if (rx_er_i && rx_dv_i) begin
					next_st.rx_err = 1'b1;
				end
			end
			default: begin
				next_st.phase = RFS_IDLE;
			end
		endcase

		// Frame completion: checks, status, counters
		if (frame_end_i && st.phase != RFS_IDLE) begin
			next_st.phase = RFS_IDLE;
			crc_bad = !crc_good_i || st.rx_err;
			is_long = long_check_en_i && (st.len > LONG_FRAME_MAX);
			frame_ok = (st.phase == RFS_DATA) && !st.missed_mem;
			inc_crc = crc_bad && !is_long;
			inc_aln = crc_bad && odd_bits_i && !is_long;
			inc_mis = st.missed_mem
				|| (monitor_mode_i && frame_ok && (!crc_bad || accept_errored_i));
			if (crc_bad && !monitor_mode_i) begin
				next_st.err_irq = 1'b1;
			end
			next_st.status = '0;
			next_st.status[ST_OK]    = frame_ok && !crc_bad;
			next_st.status[ST_CRC]   = crc_bad;
			next_st.status[ST_ALIGN] = crc_bad && odd_bits_i;
			next_st.status[ST_LONG]  = is_long;
			next_st.status[ST_MISSED] = inc_mis;
			next_st.status[ST_ABORT] = st.aborted || (crc_bad && !accept_errored_i);
			next_st.status[ST_LEN_LSB +: 11] = st.len;
			// Saved frames carry their status; others leave it to be overwritten
			if (frame_ok && !monitor_mode_i && (!crc_bad || accept_errored_i)) begin
				next_st.mstatus       = next_st.status;
				next_st.mstatus_valid = 1'b1;
				if (st.lane != 2'h0) begin
					next_st.word_valid = 1'b1;
				end
			end else if (!monitor_mode_i && frame_ok) begin
				fifo_s.flush = 1'b1;
				next_st.word_valid = 1'b0;
			end
		end

		nc = cnt_next(st.crc_cnt, inc_crc, crc_cnt_rd_i);
		na = cnt_next(st.aln_cnt, inc_aln, align_cnt_rd_i);
		nm = cnt_next(st.mis_cnt, inc_mis, missed_cnt_rd_i);
		// Edge into threshold only, so a parked counter does not re-fire
		if ((nc == CNT_IRQ_LEVEL && st.crc_cnt != CNT_IRQ_LEVEL)
			|| (na == CNT_IRQ_LEVEL && st.aln_cnt != CNT_IRQ_LEVEL)
			|| (nm == CNT_IRQ_LEVEL && st.mis_cnt != CNT_IRQ_LEVEL)) begin
			next_st.cnt_irq = 1'b1;
		end
		next_st.crc_cnt = nc;
		next_st.aln_cnt = na;
		next_st.mis_cnt = nm;
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st       <= '0;
			st.phase <= RFS_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Monitor mode never lets the drain side see a request
	assign burst_req_o            = st.req && !monitor_mode_i;
	assign mem_status_o           = st.mstatus;
	assign mem_status_valid_o     = st.mstatus_valid;
	assign rx_status_o            = st.status;
	assign overflow_irq_o         = st.ovf_irq;
	assign rx_error_irq_o         = st.err_irq;
	assign counter_irq_o          = st.cnt_irq;
	assign crc_error_counter_o    = st.crc_cnt;
	assign align_error_counter_o  = st.aln_cnt;
	assign missed_frame_counter_o = st.mis_cnt;
endmodule

// file: verif/rfs_checker.sv
/* Port assertions for rfs_top.
   Assumes one clock; bound from the bench top file. */
`timescale 1ns/100ps
module rfs_checker
	import rfs_pkg::*;
(
	input wire logic        core_clk_i,
	input wire logic        reset_n_i,
	input wire logic        monitor_mode_i,
	input wire logic        frame_end_i,
	input wire logic        burst_req_o,
	input wire logic        mem_status_valid_o,
	input wire logic [31:0] rx_status_o,
	input wire logic        rx_error_irq_o,
	input wire logic        counter_irq_o,
	input wire logic        crc_cnt_rd_i,
	input wire logic [7:0]  crc_error_counter_o,
	input wire logic [7:0]  align_error_counter_o,
	input wire logic [7:0]  missed_frame_counter_o
);
	// ****************
	// Checks
	// ****************
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	chk_burst_monitor: assert property (monitor_mode_i |-> !burst_req_o)
		else $error("burst request in monitor mode");
	chk_monitor_store: assert property (frame_end_i && monitor_mode_i |=> !mem_status_valid_o)
		else $error("frame stored in monitor mode");
	chk_read_clear: assert property (crc_cnt_rd_i |=> crc_error_counter_o <= 8'h01)
		else $error("counter not cleared by read");
	chk_count_hold: assert property (crc_error_counter_o == CNT_MAX && !crc_cnt_rd_i
		|=> crc_error_counter_o == CNT_MAX) else $error("counter left 255");
	chk_irq_cause: assert property (counter_irq_o |-> crc_error_counter_o == CNT_IRQ_LEVEL
		|| align_error_counter_o == CNT_IRQ_LEVEL || missed_frame_counter_o == CNT_IRQ_LEVEL)
		else $error("counter irq without threshold");
	chk_irq_entry: assert property (crc_error_counter_o == CNT_IRQ_LEVEL
		&& $past(crc_error_counter_o) != CNT_IRQ_LEVEL |-> counter_irq_o)
		else $error("missing counter irq");
	chk_err_quiet: assert property (frame_end_i && monitor_mode_i |=> !rx_error_irq_o)
		else $error("error irq in monitor mode");
	chk_err_irq: assert property ($past(frame_end_i) && !$past(monitor_mode_i)
		&& rx_status_o[ST_CRC] |-> rx_error_irq_o) else $error("missing error irq");
	chk_align_crc: assert property (rx_status_o[ST_ALIGN] |-> rx_status_o[ST_CRC])
		else $error("alignment without crc error");
	chk_status_hold: assert property (!$past(frame_end_i) |-> $stable(rx_status_o))
		else $error("status changed mid frame");
endmodule

// file: verif/rfs_mem_model.sv
/* Local receive memory model: acks bursts, takes words.
   Assumes the bench commands full and slow behaviour. */
`timescale 1ns/100ps
module rfs_mem_model (
	input  wire logic        core_clk_i,
	input  wire logic        burst_req_i,
	input  wire logic [31:0] data_i,
	input  wire logic        valid_i,
	input  wire logic        full_cmd_i,
	input  wire logic        slow_i,
	output logic             burst_ack_o,
	output logic             ready_o,
	output logic             full_o
);
	logic [31:0] got[$];
	initial begin
		burst_ack_o = 1'b0;
		ready_o = 1'b0;
		full_o = 1'b0;
	end
	always @(posedge core_clk_i) begin
		if (ready_o && valid_i)
			got.push_back(data_i);
		full_o <= full_cmd_i;
		burst_ack_o <= burst_req_i && !burst_ack_o;
		// Half rate on average still outruns one word per four bytes
		ready_o <= !full_cmd_i && (!slow_i || $urandom_range(1));
	end
endmodule

// file: verif/test_rx_frame_store_and_error_counters.sv
/* Self-checking bench for rfs_top with a counter model.
   Assumes rfs_mem_model and rfs_checker. */
`timescale 1ns/100ps
module test_rx_frame_store_and_error_counters
	import rfs_pkg::*;
;
	logic core_clk_i = 0, reset_n_i = 0, monitor_mode_i = 0, accept_errored_i = 0;
	logic long_check_en_i = 0, sfd_i = 0, byte_valid_i = 0, frame_end_i = 0;
	logic crc_good_i = 0, odd_bits_i = 0, rx_er_i = 0, rx_dv_i = 0, full = 0, slow = 0;
	logic addr_match_valid_i = 0, addr_match_i = 0, crc_cnt_rd_i = 0;
	logic align_cnt_rd_i = 0, missed_cnt_rd_i = 0, rh = 0;
	logic [7:0] byte_i = 0;
	logic burst_req_o, burst_ack_i, mem_valid_o, mem_ready_i, mem_full_i;
	logic mem_status_valid_o, overflow_irq_o, rx_error_irq_o, counter_irq_o;
	logic [31:0] mem_data_o, mem_status_o, rx_status_o, ew[$];
	logic [7:0] crc_error_counter_o, align_error_counter_o, missed_frame_counter_o;
	int errors = 0, num_checks = 0, ec = 0, ea = 0, em = 0, ee = 0, eo = 0, es = 0;
	int eci = 0, nc = 0, ne = 0, no = 0, ns = 0, k;
	rfs_top dut (.*);
	rfs_mem_model mem (.core_clk_i(core_clk_i), .burst_req_i(burst_req_o),
		.data_i(mem_data_o), .valid_i(mem_valid_o), .full_cmd_i(full), .slow_i(slow),
		.burst_ack_o(burst_ack_i), .ready_o(mem_ready_i), .full_o(mem_full_i));
	always #10 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) begin
		nc += (counter_irq_o === 1'b1);
		ne += (rx_error_irq_o === 1'b1);
		no += (overflow_irq_o === 1'b1);
		ns += (mem_status_valid_o === 1'b1);
	end
	// ****************
	// Tasks
	// ****************
	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("Error t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	function int inc(input int x);
		return x < 255 ? x + 1 : 255;
	endfunction
	task frame(input int n, input bit m, g, o, e, input int fa);
		bit bad, wr, lng;
		int c0, a0, m0;
		logic [31:0] w;
		logic [7:0] v;
		c0 = ec;
		a0 = ea;
		m0 = em;
		mem.got.delete();
		ew.delete();
		@(posedge core_clk_i);
		// Mode inputs settle one edge after the caller changes them
		bad = !g || e;
		lng = long_check_en_i && n > 1518;
		wr = m && !monitor_mode_i && fa == 0 && (!bad || accept_errored_i);
		sfd_i <= 1;
		rx_dv_i <= 1;
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk_i);
			if (i == 6) begin
				byte_valid_i <= 0;
				addr_match_valid_i <= 1;
				addr_match_i <= m;
				@(posedge core_clk_i);
			end
			v = $urandom;
			w = {v, w[31:8]};
			if (wr && i % 4 == 3)
				ew.push_back(w);
			sfd_i <= 0;
			addr_match_valid_i <= 0;
			byte_i <= v;
			byte_valid_i <= 1;
			rx_er_i <= e && i == 8;
			if (i == fa && fa > 0)
				full <= 1;
		end
		@(posedge core_clk_i);
		byte_valid_i <= 0;
		rx_er_i <= 0;
		frame_end_i <= 1;
		crc_good_i <= g;
		odd_bits_i <= o;
		crc_cnt_rd_i <= rh;
		@(posedge core_clk_i);
		frame_end_i <= 0;
		crc_cnt_rd_i <= 0;
		rx_dv_i <= 0;
		full <= 0;
		if (rh)
			ec = 0;
		if (m) begin
			if (bad && !lng) begin
				ec = inc(ec);
				ea = o ? inc(ea) : ea;
			end
			if (fa > 0 || monitor_mode_i && (!bad || accept_errored_i))
				em = inc(em);
			ee += bad && !monitor_mode_i;
			eo += fa > 0;
			es += wr;
			eci += ec == 192 && c0 != 192 || ea == 192 && a0 != 192 || em == 192 && m0 != 192;
		end
		for (int i = 0; mem_valid_o !== 1'b0; i++) begin
			if (i == 60) begin
				errors++;
				report_and_stop;
			end
			@(posedge core_clk_i);
		end
		repeat (3) @(posedge core_clk_i);
		chk(crc_error_counter_o, ec); // crc count
		chk(align_error_counter_o, ea); // align count
		chk(missed_frame_counter_o, em); // missed count
		chk(nc, eci); // shared irq
		chk(ne, ee); // error irq
		chk(no, eo); // overflow irq
		chk(ns, es); // stored status
		if (m) begin
			chk(rx_status_o[ST_CRC], bad); // crc flag
			chk(rx_status_o[ST_ALIGN], bad && o); // align flag
			chk(rx_status_o[ST_LONG], lng); // long flag
		end
		if (wr || monitor_mode_i) begin
			chk(mem.got.size(), ew.size()); // word count
			foreach (ew[i])
				chk(mem.got[i], ew[i]); // word data
		end
	endtask
	initial begin
		#1500000;
		errors++;
		report_and_stop;
	end
	initial begin
		k = $urandom(32'h6CBB);
		repeat (8) @(posedge core_clk_i);
		reset_n_i <= 1;
		repeat (2) @(posedge core_clk_i);
		frame(64, 1, 1, 0, 0, 0); // good frame
		slow <= 1;
		frame(36, 1, 0, 0, 0, 0); // crc abort
		accept_errored_i <= 1;
		frame(32, 1, 0, 1, 0, 0); // odd end
		frame(24, 1, 1, 0, 1, 0); // phy error
		accept_errored_i <= 0;
		frame(40, 0, 1, 0, 0, 0); // no match
		frame(64, 1, 1, 0, 0, 20); // memory full
		monitor_mode_i <= 1;
		long_check_en_i <= 1;
		frame(1520, 1, 0, 1, 0, 0); // long frame
		frame(16, 1, 1, 0, 0, 0); // monitor
		for (int i = 0; i < 260; i++)
			frame(8, 1, 0, 0, 0, 0); // saturate
		rh = 1;
		frame(8, 1, 0, 0, 0, 0); // read with count
		report_and_stop;
	end
endmodule
bind rfs_top rfs_checker chk (.*);
